// ### bbc_pkg.sv
// Shared constants for the flow-control decode and execute block
package bbc_pkg;

	localparam int PC_W   = 12;
	localparam int DATA_W = 8;
	localparam int DISP_S = 5;
	localparam int BIT_W  = 3;
	localparam int STK_DEPTH = 6;
	localparam int STK_PTR_W = 3;

	// Opcode low-field classes, bits [2:0]
	localparam logic [2:0] CLS_BR_ZC = 3'h0;
	localparam logic [2:0] CLS_EXT   = 3'h1;
	localparam logic [2:0] CLS_BR_CC = 3'h2;
	localparam logic [2:0] CLS_BIT   = 3'h3;
	localparam logic [2:0] CLS_BR_ZS = 3'h4;
	localparam logic [2:0] CLS_BR_CS = 3'h6;

	// Field positions inside the opcode
	localparam int OP_SUB_POS  = 3;
	localparam int OP_POL_POS  = 4;
	localparam int OP_HI_LSB   = 4;
	localparam int OP_DISP_LSB = 3;

	// Control instructions
	localparam logic [7:0] OP_IDLE     = 8'h05;
	localparam logic [7:0] OP_SUB_EXIT = 8'h25;
	localparam logic [7:0] OP_INT_EXIT = 8'h45;
	localparam logic [7:0] OP_STOP     = 8'h65;
	localparam logic [7:0] OP_WAIT     = 8'h85;

	// Distance from the instruction address to the base of each offset
	localparam logic [PC_W-1:0] SHORT_BASE = 12'h001;
	localparam logic [PC_W-1:0] LONG_BASE  = 12'h002;

	localparam logic [PC_W-1:0]   PC_RST   = 12'h000;
	localparam logic [DATA_W-1:0] BYTE_RST = 8'h00;

	typedef enum logic [2:0] {
		BBC_FETCH = 3'b000,
		BBC_DEC   = 3'b001,
		BBC_OP2   = 3'b010,
		BBC_EXT   = 3'b011,
		BBC_RD    = 3'b100,
		BBC_DISP  = 3'b101,
		BBC_HALT  = 3'b110
	} bbc_state_e;

endpackage : bbc_pkg

// ### bbc_ret_stack.sv
// Return address stack with a registered top-of-stack output
`timescale 1ns/100ps
module bbc_ret_stack (
	input  wire logic                     clk,
	input  wire logic                     nrst,
	input  wire logic                     push,
	input  wire logic                     pop,
	input  wire logic [bbc_pkg::PC_W-1:0] wdata,
	output logic      [bbc_pkg::PC_W-1:0] top_q
);
	logic [bbc_pkg::PC_W-1:0]      mem_q [bbc_pkg::STK_DEPTH];
	logic [bbc_pkg::STK_PTR_W-1:0] sp_q;

	////////////////////////////////////////////////////////////////////////
	// Overflow wraps silently, as a small hardware stack does
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sp_q <= '0;
		end else if (push) begin
			sp_q <= (sp_q == 3'(bbc_pkg::STK_DEPTH - 1)) ? '0 : sp_q + 3'h1;
		end else if (pop) begin
			sp_q <= (sp_q == '0) ? 3'(bbc_pkg::STK_DEPTH - 1) : sp_q - 3'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[sp_q] <= wdata;
		end
	end

	// Top kept current so a return needs no extra read cycle
	always_ff @(posedge clk) begin
		if (!nrst) begin
			top_q <= bbc_pkg::PC_RST;
		end else if (push) begin
			top_q <= wdata;
		end else if (pop) begin
			top_q <= mem_q[(sp_q < 3'h2) ? sp_q + 3'(bbc_pkg::STK_DEPTH - 2)
				: sp_q - 3'h2];
		end
	end

endmodule : bbc_ret_stack

// ### bbc_core.sv
// Decode and execute of branch, bit, jump and control instructions
`timescale 1ns/100ps
// Operation
// - A conditional branch is taken only if its condition holds.
// - Short branches carry a 5-bit signed offset, -15 to +16.
// - Bit-test branches carry an 8-bit signed offset, -126 to +129.
// - A bit-test branch copies the tested bit into carry.
// - Bit operations reach any bit of any data byte by a 3-bit field.
// - Bit set forces the chosen bit to one and bit clear to zero.
// - Branch-if-bit-clear jumps on zero, branch-if-bit-set on one.
// - Long jump and call load a 12-bit absolute target.
// - With the watchdog selected, stop is replaced by a wait.
module bbc_core (
	input  wire logic                       clk,
	input  wire logic                       nrst,
	input  wire logic [bbc_pkg::DATA_W-1:0] pm_data,
	input  wire logic [bbc_pkg::DATA_W-1:0] ds_rdata,
	input  wire logic                       watchdog_sel,
	input  wire logic                       wake,
	input  wire logic                       saved_z,
	input  wire logic                       saved_c,
	output logic      [bbc_pkg::PC_W-1:0]   pm_addr_q,
	output logic      [bbc_pkg::DATA_W-1:0] ds_addr_q,
	output logic      [bbc_pkg::DATA_W-1:0] ds_wdata_q,
	output logic                            ds_we_q,
	output logic                            flag_z_q,
	output logic                            flag_c_q,
	output logic                            stop_q,
	output logic                            wait_q,
	output logic                            foreign_op_q
);
	bbc_pkg::bbc_state_e              st_q;
	logic [bbc_pkg::PC_W-1:0]         pc_q;
	logic [bbc_pkg::DATA_W-1:0]       op_q;
	logic [bbc_pkg::DATA_W-1:0]       b2_q;
	logic [bbc_pkg::PC_W-1:0]         ret_top;
	logic                             stk_push;
	logic                             stk_pop;

	// Decode of the opcode currently on the program bus and of the latched opcode op_q
	logic [2:0]                       cls;
	logic                             is_pcr;
	logic                             pcr_cond;
	logic [bbc_pkg::PC_W-1:0]         pcr_target;
	logic [bbc_pkg::PC_W-1:0]         fall_pc;
	logic                             is_ctrl;
	logic [bbc_pkg::BIT_W-1:0]        bit_sel;
	logic                             tested;
	logic [bbc_pkg::PC_W-1:0]         bt_target;
	logic [bbc_pkg::PC_W-1:0]         ext_target;
	logic [bbc_pkg::DATA_W-1:0]       bit_mask;

	assign cls      = pm_data[2:0];
	assign is_pcr   = (cls == bbc_pkg::CLS_BR_ZC) || (cls == bbc_pkg::CLS_BR_CC)
		|| (cls == bbc_pkg::CLS_BR_ZS) || (cls == bbc_pkg::CLS_BR_CS);
	assign is_ctrl  = (pm_data == bbc_pkg::OP_IDLE)
		|| (pm_data == bbc_pkg::OP_SUB_EXIT)
		|| (pm_data == bbc_pkg::OP_INT_EXIT)
		|| (pm_data == bbc_pkg::OP_STOP) || (pm_data == bbc_pkg::OP_WAIT);
	assign fall_pc  = pc_q + bbc_pkg::SHORT_BASE;

	always_comb begin
		case (cls)
			bbc_pkg::CLS_BR_CS: pcr_cond = flag_c_q;
			bbc_pkg::CLS_BR_CC: pcr_cond = !flag_c_q;
			bbc_pkg::CLS_BR_ZS: pcr_cond = flag_z_q;
			bbc_pkg::CLS_BR_ZC: pcr_cond = !flag_z_q;
			default:            pcr_cond = 1'b0;
		endcase
	end

	// Signed 5-bit offset in opcode bits [7:3] gives -15..+16
	assign pcr_target = fall_pc + {{(bbc_pkg::PC_W - bbc_pkg::DISP_S)
		{pm_data[7]}}, pm_data[7:bbc_pkg::OP_DISP_LSB]};

	// Bit index is stored bit-reversed in the opcode
	assign bit_sel  = {op_q[5], op_q[6], op_q[7]};
	assign bit_mask = 8'(8'h01 << bit_sel);
	assign tested   = ds_rdata[bit_sel];
	assign bt_target = pc_q + bbc_pkg::LONG_BASE
		+ {{(bbc_pkg::PC_W - bbc_pkg::DATA_W){pm_data[7]}}, pm_data};
	assign ext_target = {op_q[7:bbc_pkg::OP_HI_LSB], pm_data};

	assign stk_push = (st_q == bbc_pkg::BBC_EXT) && !op_q[bbc_pkg::OP_SUB_POS];
	assign stk_pop  = (st_q == bbc_pkg::BBC_DEC)
		&& ((pm_data == bbc_pkg::OP_SUB_EXIT)
		|| (pm_data == bbc_pkg::OP_INT_EXIT));

	bbc_ret_stack u_stack (
		.clk   (clk),
		.nrst  (nrst),
		.push  (stk_push),
		.pop   (stk_pop),
		.wdata (pc_q + bbc_pkg::LONG_BASE),
		.top_q (ret_top)
	);

	////////////////////////////////////////////////////////////////////////
	// Sequencer: pc_q holds the address of the instruction being run
	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_q      <= bbc_pkg::BBC_FETCH;
			pc_q      <= bbc_pkg::PC_RST;
			pm_addr_q <= bbc_pkg::PC_RST;
			op_q      <= bbc_pkg::BYTE_RST;
			b2_q      <= bbc_pkg::BYTE_RST;
		end else begin
			case (st_q)
				bbc_pkg::BBC_FETCH: begin
					st_q <= bbc_pkg::BBC_DEC;
				end
				bbc_pkg::BBC_DEC: begin
					op_q <= pm_data;
					if (is_pcr) begin
						pc_q      <= pcr_cond ? pcr_target : fall_pc;
						pm_addr_q <= pcr_cond ? pcr_target : fall_pc;
						st_q      <= bbc_pkg::BBC_FETCH;
					end else if (is_ctrl) begin
						if (stk_pop) begin
							pc_q      <= ret_top;
							pm_addr_q <= ret_top;
						end else begin
							pc_q      <= fall_pc;
							pm_addr_q <= fall_pc;
						end
						st_q <= ((pm_data == bbc_pkg::OP_STOP)
							|| (pm_data == bbc_pkg::OP_WAIT))
							? bbc_pkg::BBC_HALT : bbc_pkg::BBC_FETCH;
					end else if ((cls == bbc_pkg::CLS_EXT)
						|| (cls == bbc_pkg::CLS_BIT)) begin
						pm_addr_q <= fall_pc;
						st_q      <= bbc_pkg::BBC_OP2;
					end else begin
						// Other groups own these; skip one byte
						pc_q      <= fall_pc;
						pm_addr_q <= fall_pc;
						st_q      <= bbc_pkg::BBC_FETCH;
					end
				end
				bbc_pkg::BBC_OP2: begin
					b2_q <= pm_data;
					st_q <= (op_q[2:0] == bbc_pkg::CLS_EXT)
						? bbc_pkg::BBC_EXT : bbc_pkg::BBC_RD;
				end
				bbc_pkg::BBC_EXT: begin
					pc_q      <= {op_q[7:bbc_pkg::OP_HI_LSB], b2_q};
					pm_addr_q <= {op_q[7:bbc_pkg::OP_HI_LSB], b2_q};
					st_q      <= bbc_pkg::BBC_FETCH;
				end
				bbc_pkg::BBC_RD: begin
					if (op_q[bbc_pkg::OP_SUB_POS]) begin
						pc_q      <= pc_q + bbc_pkg::LONG_BASE;
						pm_addr_q <= pc_q + bbc_pkg::LONG_BASE;
						st_q      <= bbc_pkg::BBC_FETCH;
					end else begin
						pm_addr_q <= pc_q + bbc_pkg::LONG_BASE;
						st_q      <= bbc_pkg::BBC_DISP;
					end
				end
				bbc_pkg::BBC_DISP: begin
					// Polarity bit set means jump on one
					if (flag_c_q == op_q[bbc_pkg::OP_POL_POS]) begin
						pc_q      <= bt_target;
						pm_addr_q <= bt_target;
					end else begin
						pc_q      <= pc_q + 12'h003;
						pm_addr_q <= pc_q + 12'h003;
					end
					st_q <= bbc_pkg::BBC_FETCH;
				end
				bbc_pkg::BBC_HALT: begin
					if (wake) begin
						st_q <= bbc_pkg::BBC_FETCH;
					end
				end
				default: st_q <= bbc_pkg::BBC_FETCH;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Data space access for bit set, bit clear and bit test
	always_ff @(posedge clk) begin
		if (!nrst) begin
			ds_addr_q  <= bbc_pkg::BYTE_RST;
			ds_wdata_q <= bbc_pkg::BYTE_RST;
			ds_we_q    <= 1'b0;
		end else begin
			ds_we_q <= 1'b0;
			if (st_q == bbc_pkg::BBC_OP2) begin
				ds_addr_q <= pm_data;
			end
			if ((st_q == bbc_pkg::BBC_RD) && op_q[bbc_pkg::OP_SUB_POS]) begin
				ds_we_q    <= 1'b1;
				ds_wdata_q <= op_q[bbc_pkg::OP_POL_POS]
					? (ds_rdata | bit_mask) : (ds_rdata & ~bit_mask);
			end
		end
	end

	// Flags: only the bit test and interrupt exit touch them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag_z_q <= 1'b0;
			flag_c_q <= 1'b0;
		end else if ((st_q == bbc_pkg::BBC_RD)
			&& !op_q[bbc_pkg::OP_SUB_POS]) begin
			flag_c_q <= tested;
		end else if ((st_q == bbc_pkg::BBC_DEC)
			&& (pm_data == bbc_pkg::OP_INT_EXIT)) begin
			flag_z_q <= saved_z;
			flag_c_q <= saved_c;
		end
	end

	// Low-power requests stand while halted
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stop_q       <= 1'b0;
			wait_q       <= 1'b0;
			foreign_op_q <= 1'b0;
		end else begin
			foreign_op_q <= (st_q == bbc_pkg::BBC_DEC) && !is_pcr && !is_ctrl
				&& (cls != bbc_pkg::CLS_EXT) && (cls != bbc_pkg::CLS_BIT);
			if (st_q == bbc_pkg::BBC_DEC) begin
				stop_q <= (pm_data == bbc_pkg::OP_STOP) && !watchdog_sel;
				wait_q <= (pm_data == bbc_pkg::OP_WAIT)
					|| ((pm_data == bbc_pkg::OP_STOP) && watchdog_sel);
			end else if ((st_q == bbc_pkg::BBC_HALT) && wake) begin
				stop_q <= 1'b0;
				wait_q <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_short_op;
		(st_q == bbc_pkg::BBC_DEC) && (is_pcr || is_ctrl)
			&& (pm_data != bbc_pkg::OP_STOP) && (pm_data != bbc_pkg::OP_WAIT);
	endsequence

	a_branch_target: assert property ((st_q == bbc_pkg::BBC_DEC) && is_pcr
		|=> pc_q == ($past(pcr_cond) ? $past(pcr_target)
		: $past(pc_q) + 12'h001))
		else $error("short branch went to wrong address");
	a_short_reach: assert property ((st_q == bbc_pkg::BBC_DEC) && is_pcr
		|=> ($signed(pc_q - $past(pc_q)) >= -12'sd15)
		&& ($signed(pc_q - $past(pc_q)) <= 12'sd16))
		else $error("short branch out of reach");
	a_long_reach: assert property (st_q == bbc_pkg::BBC_DISP
		|=> ($signed(pc_q - $past(pc_q)) >= -12'sd126)
		&& ($signed(pc_q - $past(pc_q)) <= 12'sd129))
		else $error("bit test branch out of reach");
	a_carry_copy: assert property ((st_q == bbc_pkg::BBC_RD)
		&& !op_q[bbc_pkg::OP_SUB_POS]
		|=> flag_c_q == $past(ds_rdata[bit_sel]))
		else $error("tested bit not copied to carry");
	a_bit_write: assert property ((st_q == bbc_pkg::BBC_RD)
		&& op_q[bbc_pkg::OP_SUB_POS] |=> ds_we_q
		&& (ds_wdata_q[$past(bit_sel)] == $past(op_q[bbc_pkg::OP_POL_POS]))
		&& ds_addr_q == $past(ds_addr_q))
		else $error("bit set or clear wrote wrong value");
	a_bit_branch: assert property (st_q == bbc_pkg::BBC_DISP
		|=> (pc_q == $past(bt_target))
		== ($past(flag_c_q) == $past(op_q[bbc_pkg::OP_POL_POS]))
		|| ($past(bt_target) == $past(pc_q) + 12'h003))
		else $error("bit test branch decision wrong");
	a_long_target: assert property (st_q == bbc_pkg::BBC_OP2
		&& op_q[2:0] == bbc_pkg::CLS_EXT
		|=> ##1 pc_q == $past(ext_target, 2))
		else $error("long jump target wrong");
	a_stop_to_wait: assert property ((st_q == bbc_pkg::BBC_DEC)
		&& (pm_data == bbc_pkg::OP_STOP) && watchdog_sel
		|=> wait_q && !stop_q)
		else $error("stop not replaced by wait");
	a_flags_hold: assert property ((s_short_op
		and (pm_data != bbc_pkg::OP_INT_EXIT))
		|=> $stable(flag_z_q) && $stable(flag_c_q))
		else $error("short instruction changed flags");
	a_short_time: assert property (s_short_op
		|=> st_q == bbc_pkg::BBC_FETCH ##1 st_q == bbc_pkg::BBC_DEC)
		else $error("short instruction not two cycles");
	a_test_time: assert property ((st_q == bbc_pkg::BBC_DEC)
		&& (cls == bbc_pkg::CLS_BIT) && !pm_data[bbc_pkg::OP_SUB_POS]
		|=> st_q == bbc_pkg::BBC_OP2 ##1 st_q == bbc_pkg::BBC_RD
		##1 st_q == bbc_pkg::BBC_DISP ##1 st_q == bbc_pkg::BBC_FETCH)
		else $error("bit test not five cycles");

endmodule : bbc_core

// ### bbc_mem_model.sv
// Program memory and data space facing the flow-control core
`timescale 1ns/100ps
module bbc_mem_model (
	input  wire logic                       clk,
	input  wire logic [bbc_pkg::PC_W-1:0]   pm_addr,
	input  wire logic [bbc_pkg::DATA_W-1:0] ds_addr,
	input  wire logic [bbc_pkg::DATA_W-1:0] ds_wdata,
	input  wire logic                       ds_we,
	output logic      [bbc_pkg::DATA_W-1:0] pm_data,
	output logic      [bbc_pkg::DATA_W-1:0] ds_rdata
);
	logic [7:0] pmem [0:4095];
	logic [7:0] dmem [0:255];
	// Unwritten program space reads as a foreign opcode, never unknown
	initial begin
		for (int i = 0; i < 4096; i++) begin
			pmem[i] = 8'hFF;
		end
	end
	assign pm_data  = pmem[pm_addr];
	assign ds_rdata = dmem[ds_addr];
	always @(posedge clk) begin
		if (ds_we) begin
			dmem[ds_addr] <= ds_wdata;
		end
	end
endmodule : bbc_mem_model

// ### branch_bit_control_decode_tb.sv
// Self-checking bench for the flow-control decode and execute core
`timescale 1ns/100ps
`define CHK(got, exp) begin \
	n_compared++; \
	if ((got) !== (exp)) begin \
		failures++; \
		$display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
	end \
end
module branch_bit_control_decode_tb;
	localparam int LIMIT = 6000;
	logic        clk;
	logic        nrst;
	logic        watchdog_sel;
	logic        wake;
	logic        saved_z;
	logic        saved_c;
	logic [7:0]  pm_data;
	logic [7:0]  ds_rdata;
	logic [11:0] pm_addr_q;
	logic [7:0]  ds_addr_q;
	logic [7:0]  ds_wdata_q;
	logic        ds_we_q;
	logic        flag_z_q;
	logic        flag_c_q;
	logic        stop_q;
	logic        wait_q;
	logic        foreign_op_q;
	int          failures;
	int          n_compared;
	int          cycles;
	logic [31:0] seed;
	logic [11:0] pc;
	logic        z_m;
	logic        c_m;
	logic [11:0] stk [$];

	bbc_core bbc_core_i (.clk(clk), .nrst(nrst), .pm_data(pm_data),
		.ds_rdata(ds_rdata), .watchdog_sel(watchdog_sel), .wake(wake),
		.saved_z(saved_z), .saved_c(saved_c), .pm_addr_q(pm_addr_q),
		.ds_addr_q(ds_addr_q), .ds_wdata_q(ds_wdata_q), .ds_we_q(ds_we_q),
		.flag_z_q(flag_z_q), .flag_c_q(flag_c_q), .stop_q(stop_q),
		.wait_q(wait_q), .foreign_op_q(foreign_op_q));
	bbc_mem_model mdl (.clk(clk), .pm_addr(pm_addr_q), .ds_addr(ds_addr_q),
		.ds_wdata(ds_wdata_q), .ds_we(ds_we_q), .pm_data(pm_data),
		.ds_rdata(ds_rdata));

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			wrap_up();
		end
	end

	////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function automatic logic [11:0] rel5(logic [11:0] a, logic [7:0] op,
			logic cond);
		return cond ? a + 12'h001 + {{7{op[7]}}, op[7:3]} : a + 12'h001;
	endfunction : rel5
	task automatic drive_rand();
		logic [31:0] r;
		r = xs();
		saved_z      <= r[0];
		saved_c      <= r[1];
		watchdog_sel <= r[2];
	endtask : drive_rand

	// Places one instruction at pc, runs it and checks where it lands
	task automatic run_op(input logic [7:0] op, input logic [7:0] b1,
			input logic [7:0] b2, input logic [7:0] dv);
		logic [11:0] a;
		logic [11:0] nxt;
		logic [2:0]  idx;
		logic [7:0]  wdat;
		logic        wr;
		logic        frn;
		logic        halt;
		logic        wd;
		int          ncyc;
		a = pc;
		idx = {op[5], op[6], op[7]};
		wdat = dv;
		wr = 1'b0;
		frn = 1'b0;
		halt = 1'b0;
		wd = watchdog_sel;
		ncyc = 2;
		nxt = a + 12'h001;
		mdl.pmem[a] = op;
		mdl.pmem[a + 12'h001] = b1;
		mdl.pmem[a + 12'h002] = b2;
		case (op[2:0])
			bbc_pkg::CLS_BR_ZC: nxt = rel5(a, op, !z_m);
			bbc_pkg::CLS_BR_CC: nxt = rel5(a, op, !c_m);
			bbc_pkg::CLS_BR_ZS: nxt = rel5(a, op, z_m);
			bbc_pkg::CLS_BR_CS: nxt = rel5(a, op, c_m);
			bbc_pkg::CLS_EXT: begin
				nxt = {op[7:4], b1};
				ncyc = 4;
				if (!op[3]) begin
					stk.push_back(a + 12'h002);
				end
			end
			bbc_pkg::CLS_BIT: begin
				if (op[3]) begin
					wdat[idx] = op[4];
					wr = 1'b1;
					nxt = a + 12'h002;
					ncyc = 4;
				end else begin
					c_m = dv[idx];
					nxt = (dv[idx] == op[4]) ?
						a + 12'h002 + {{4{b2[7]}}, b2} : a + 12'h003;
					ncyc = 5;
				end
			end
			3'h5: begin
				if (op == bbc_pkg::OP_SUB_EXIT || op == bbc_pkg::OP_INT_EXIT) begin
					nxt = stk.pop_back();
				end
				if (op == bbc_pkg::OP_INT_EXIT) begin
					z_m = saved_z;
					c_m = saved_c;
				end
				halt = (op == bbc_pkg::OP_STOP || op == bbc_pkg::OP_WAIT);
				frn = !(op inside {bbc_pkg::OP_IDLE, bbc_pkg::OP_SUB_EXIT,
					bbc_pkg::OP_INT_EXIT, bbc_pkg::OP_STOP, bbc_pkg::OP_WAIT});
			end
			default: frn = 1'b1;
		endcase
		@(posedge clk);
		#1;
		mdl.dmem[b1] = dv;
		repeat (ncyc - 1) @(posedge clk);
		if (halt) begin
			#1;
			`CHK(wait_q, op == bbc_pkg::OP_WAIT || wd)
			`CHK(stop_q, op == bbc_pkg::OP_STOP && !wd)
			repeat (xs() % 3 + 1) @(posedge clk);
			`CHK({stop_q, wait_q, pm_addr_q}, {op == bbc_pkg::OP_STOP && !wd,
				op == bbc_pkg::OP_WAIT || wd, nxt})
			wake <= 1'b1;
			@(posedge clk);
			wake <= 1'b0;
			drive_rand();
			#1;
			`CHK({stop_q, wait_q}, 2'b00)
		end else begin
			drive_rand();
			#1;
		end
		`CHK(pm_addr_q, nxt)
		`CHK({flag_z_q, flag_c_q}, {z_m, c_m})
		`CHK({ds_we_q, foreign_op_q}, {wr, frn})
		if (wr) begin
			`CHK({ds_addr_q, ds_wdata_q}, {b1, wdat})
		end
		pc = nxt;
	endtask : run_op

	// One random instruction; extremes of the offsets are favoured
	task automatic rand_op();
		logic [31:0] r;
		logic [7:0]  op;
		logic [7:0]  b2;
		r = xs();
		op = r[7:0];
		b2 = r[28] ? (r[29] ? 8'h80 : 8'h7F) : r[23:16];
		if (r[30]) begin
			op[7:3] = r[29] ? 5'h10 : 5'h0F;
		end
		case (r[10:8] % 5)
			0: op[0] = 1'b0;
			1: op = {op[7:4], op[3] | (stk.size() >= 5), 3'h1};
			2: op[2:0] = 3'h3;
			3: begin
				op = 8'h05 + 8'h20 * (r[15:12] % 5);
				if (stk.size() == 0 && (op == 8'h25 || op == 8'h45)) begin
					op = bbc_pkg::OP_IDLE;
				end
			end
			default: op[2:0] = 3'h7;
		endcase
		run_op(op, r[15:8], b2, r[31:24]);
	endtask : rand_op

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	////////////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		wake = 1'b0;
		saved_z = 1'b0;
		saved_c = 1'b0;
		watchdog_sel = 1'b0;
		failures = 0;
		n_compared = 0;
		cycles = 0;
		seed = 32'h0000_0008;
		pc = 12'h000;
		z_m = 1'b0;
		c_m = 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		#1;
		`CHK({pm_addr_q, flag_z_q, flag_c_q, stop_q, wait_q}, 16'h0000)
		$display("test reset done");
		run_op(8'h80, 8'h00, 8'h00, 8'h00);
		run_op(8'h7E, 8'h00, 8'h00, 8'h00);
		run_op(8'hF3, 8'h10, 8'h80, 8'h80);
		run_op(8'h63, 8'h11, 8'h7F, 8'hBF);
		run_op(8'h0B, 8'h12, 8'h00, 8'hFF);
		run_op(8'h15, 8'h00, 8'h00, 8'h00);
		$display("test directed done");
		repeat (400) rand_op();
		$display("test random done");
		wrap_up();
	end
endmodule : branch_bit_control_decode_tb
